// >>> verilog/pbc_pkg.sv
// Purpose: shared constants and types of the PHY basic control block
// Assumes: 100 MHz reference clock, 32-entry management register space
// Notes:   status word is mostly fixed capability bits
package pbc_pkg;

  // register addresses on the management link
  localparam logic [4:0]  REG_CTRL = 5'h00;
  localparam logic [4:0]  REG_STAT = 5'h01;

  // control field positions
  localparam int unsigned CTRL_RESET    = 15;
  localparam int unsigned CTRL_LOOPBACK = 14;
  localparam int unsigned CTRL_SPEED    = 13;
  localparam int unsigned CTRL_AN_EN    = 12;
  localparam int unsigned CTRL_PDOWN    = 11;
  localparam int unsigned CTRL_ISOLATE  = 10;
  localparam int unsigned CTRL_AN_RST   = 9;
  localparam int unsigned CTRL_DUPLEX   = 8;
  localparam int unsigned CTRL_COLTEST  = 7;

  // status field positions and fixed content
  localparam int unsigned STAT_AN_DONE  = 5;
  localparam int unsigned STAT_LINK     = 2;
  localparam logic [15:0] STAT_FIXED    = 16'h7848;

  // values held between hardware reset and the strap capture
  localparam logic        RST_SPEED     = 1'h1;
  localparam logic        RST_AN_EN     = 1'h1;
  localparam logic        RST_ISOLATE   = 1'h0;
  localparam logic        RST_DUPLEX    = 1'h1;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SRST_TIME_NS  = 100;
  localparam int unsigned SRST_CYCLES   =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRAP_WAIT    = 3;
  localparam int unsigned HDR_BITS      = 12;
  localparam int unsigned DATA_BITS     = 16;
  localparam int unsigned SKIP_BITS     = 18;

  // strapping pins, as levels on the pins
  typedef struct packed {
    logic speed_100;
    logic autoneg_enable_strap;
    logic isolate;
    logic duplex;
  } pbc_strap_type;

  // one register write from the management link
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] data;
  } pbc_wr_type;

  typedef enum logic [2:0] {
    MD_IDLE  = 3'b000,
    MD_START = 3'b001,
    MD_HDR   = 3'b010,
    MD_TA    = 3'b011,
    MD_WDATA = 3'b100,
    MD_RDATA = 3'b101,
    MD_SKIP  = 3'b110
  } pbc_mdio_state_type;

endpackage

// >>> verilog/pbc_mdio_slave.sv
// Purpose: management frame slave on the MDC/MDIO pins
// Assumes: MDC far slower than the reference clock
// Notes:   preamble may be suppressed; a 0 then 1 opens a frame
`timescale 1ns/10ps
module pbc_mdio_slave #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  // clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_b_i,
  // management pins
  input  wire logic               mdc_i,
  input  wire logic               mdio_i,
  output logic                    mdio_o,
  output logic                    mdio_oe_o,
  // register side
  output logic [4:0]              rd_addr_o,
  input  wire logic [15:0]        rd_data_i,
  output pbc_pkg::pbc_wr_type     wr_o,
  output logic                    wr_stb_o
);
  import pbc_pkg::*;

  logic                mdc_m;
  logic                mdc_s;
  logic                mdc_d;
  logic                mdio_m;
  logic                mdio_s;
  logic                rise;
  logic [11:0]         hdr;
  logic [11:0]         next_hdr;
  logic [15:0]         shreg;
  logic [4:0]          cnt;
  logic                is_read;
  pbc_mdio_state_type  state;

  //////////////////////////////////////////////////////////////////////////
  // pins cross in through two flops each
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mdc_m  <= 1'h0;
      mdc_s  <= 1'h0;
      mdc_d  <= 1'h0;
      mdio_m <= 1'h1;
      mdio_s <= 1'h1;
    end
    else
    begin
      mdc_m  <= mdc_i;
      mdc_s  <= mdc_m;
      mdc_d  <= mdc_s;
      mdio_m <= mdio_i;
      mdio_s <= mdio_m;
    end
  end

  assign rise     = mdc_s & ~mdc_d;
  assign next_hdr = {hdr[10:0], mdio_s};

  //////////////////////////////////////////////////////////////////////////
  // frame sequencer; never gated by power down
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state     <= MD_IDLE;
      cnt       <= 5'h00;
      hdr       <= 12'h000;
      shreg     <= 16'h0000;
      is_read   <= 1'h0;
      rd_addr_o <= 5'h00;
    end
    else if (rise)
    begin
      unique case (state)
        MD_IDLE:
          if (!mdio_s) state <= MD_START;
        MD_START:
        begin
          state <= mdio_s ? MD_HDR : MD_IDLE;
          cnt   <= 5'h00;
        end
        MD_HDR:
        begin
          hdr <= next_hdr;
          cnt <= cnt + 5'h01;
          if (cnt == 5'(HDR_BITS - 1))
          begin
            cnt <= 5'h00;
            // a frame for another address is skipped whole
            if (next_hdr[9:5] == PHY_ADDR &&
                (next_hdr[11:10] == 2'h2 || next_hdr[11:10] == 2'h1))
            begin
              state     <= MD_TA;
              is_read   <= next_hdr[11:10] == 2'h2;
              rd_addr_o <= next_hdr[4:0];
            end
            else
              state <= MD_SKIP;
          end
        end
        MD_TA:
          if (is_read)
          begin
            state <= MD_RDATA;
            shreg <= rd_data_i;
            cnt   <= 5'h00;
          end
          else if (cnt == 5'h01)
          begin
            state <= MD_WDATA;
            cnt   <= 5'h00;
          end
          else
            cnt <= cnt + 5'h01;
        MD_WDATA:
        begin
          shreg <= {shreg[14:0], mdio_s};
          cnt   <= cnt + 5'h01;
          if (cnt == 5'(DATA_BITS - 1)) state <= MD_IDLE;
        end
        MD_RDATA:
        begin
          shreg <= {shreg[14:0], 1'h0};
          cnt   <= cnt + 5'h01;
          if (cnt == 5'(DATA_BITS)) state <= MD_IDLE;
        end
        MD_SKIP:
        begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'(SKIP_BITS - 1)) state <= MD_IDLE;
        end
        default:
          state <= MD_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write strobe to the register file
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_stb_o <= 1'h0;
      wr_o     <= '0;
    end
    else
    begin
      wr_stb_o <= rise && state == MD_WDATA && cnt == 5'(DATA_BITS - 1);
      if (rise && state == MD_WDATA && cnt == 5'(DATA_BITS - 1))
        wr_o <= '{addr: rd_addr_o, data: {shreg[14:0], mdio_s}};
    end
  end

  // data out changes just after the rising MDC edge
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mdio_o    <= 1'h1;
      mdio_oe_o <= 1'h0;
    end
    else if (rise)
    begin
      mdio_oe_o <= (state == MD_TA && is_read) ||
                   (state == MD_RDATA && cnt != 5'(DATA_BITS));
      mdio_o    <= state == MD_RDATA ? shreg[15] : 1'h0;
    end
  end

  turn_drive_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (rise && state == MD_TA && is_read) |=> (mdio_oe_o && !mdio_o))
    else $error("read turnaround not driven low");

endmodule // pbc_mdio_slave

// >>> verilog/pbc_phy_ctrl.sv
// Purpose: basic control and status registers of a 10/100 PHY
// Assumes: auto-negotiation engine runs on ref_clk_i
// Notes:   strap pins are captured a few cycles after hardware or soft reset, but not after the reset write that ends power down
`timescale 1ns/10ps
module pbc_phy_ctrl #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  // management pins
  input  wire logic                  mdc_i,
  input  wire logic                  mdio_i,
  output logic                       mdio_o,
  output logic                       mdio_oe_o,
  // strapping pins
  input  wire pbc_pkg::pbc_strap_type strap_i,
  // auto-negotiation engine and line state
  input  wire logic                  an_done_i,
  input  wire logic                  an_speed_100_i,
  input  wire logic                  an_full_duplex_i,
  input  wire logic                  link_up_i,
  // core controls
  output logic                       core_enable_o,
  output logic                       core_reset_o,
  output logic                       loopback_o,
  output logic                       isolate_o,
  output logic                       col_test_o,
  output logic                       an_enable_o,
  output logic                       an_restart_o,
  output logic                       speed_100_o,
  output logic                       full_duplex_o
);
  import pbc_pkg::*;

  localparam int SRST_CHK = SRST_CYCLES + 1;

  if (SRST_CYCLES < 1 || SRST_CYCLES > 255 || STRAP_WAIT < 1 ||
      STRAP_WAIT > 255)
    $error("reset counts do not fit the 8-bit counter");

  pbc_strap_type strap_m;
  pbc_strap_type strap_s;
  pbc_wr_type    wr;
  logic          wr_stb;
  logic [4:0]    rd_addr;
  logic [15:0]   rd_data;
  logic [15:0]   ctrl_word;
  logic [7:0]    load_cnt;
  logic          busy;
  logic          strap_load;
  logic          ctrl_wr;
  logic          srst_start;
  logic          wake_wr;
  logic          plain_wr;
  logic          loopback;
  logic          speed;
  logic          an_en;
  logic          pd;
  logic          iso;
  logic          restart;
  logic          duplex;
  logic          col;

  //////////////////////////////////////////////////////////////////////////
  // management link; keeps serving while powered down
  pbc_mdio_slave #(
    .PHY_ADDR (PHY_ADDR)
  ) u_mdio (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .mdc_i     (mdc_i),
    .mdio_i    (mdio_i),
    .mdio_o    (mdio_o),
    .mdio_oe_o (mdio_oe_o),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .wr_o      (wr),
    .wr_stb_o  (wr_stb)
  );

  //////////////////////////////////////////////////////////////////////////
  // strap pins come from outside, so two flops first
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      strap_m <= '0;
      strap_s <= '0;
    end
    else
    begin
      strap_m <= strap_i;
      strap_s <= strap_m;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reset sequencer: waits out the synchroniser after hardware reset,
  // and times the soft reset; defaults load as the count ends
  assign busy       = load_cnt != 8'h00;
  assign strap_load = load_cnt == 8'h01;
  assign ctrl_wr    = wr_stb && wr.addr == REG_CTRL && !busy;
  assign srst_start = ctrl_wr && wr.data[CTRL_RESET] && !pd;
  assign wake_wr    = ctrl_wr && wr.data[CTRL_RESET] && pd;
  assign plain_wr   = ctrl_wr && !wr.data[CTRL_RESET];

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      load_cnt <= 8'(STRAP_WAIT);
    else if (srst_start)
      load_cnt <= 8'(SRST_CYCLES);
    else if (busy)
      load_cnt <= load_cnt - 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////
  // control fields
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      loopback <= 1'h0;
      speed    <= RST_SPEED;
      an_en    <= RST_AN_EN;
      pd       <= 1'h0;
      iso      <= RST_ISOLATE;
      duplex   <= RST_DUPLEX;
      col      <= 1'h0;
    end
    else if (strap_load)
    begin
      loopback <= 1'h0;
      speed    <= strap_s.speed_100;
      an_en    <= strap_s.autoneg_enable_strap;
      pd       <= 1'h0;
      iso      <= strap_s.isolate;
      duplex   <= ~strap_s.duplex;
      col      <= 1'h0;
    end
    else if (wake_wr)
      pd <= 1'h0;
    else if (plain_wr)
    begin
      loopback <= wr.data[CTRL_LOOPBACK];
      speed    <= wr.data[CTRL_SPEED];
      an_en    <= wr.data[CTRL_AN_EN];
      pd       <= wr.data[CTRL_PDOWN];
      iso      <= wr.data[CTRL_ISOLATE];
      duplex   <= wr.data[CTRL_DUPLEX];
      col      <= wr.data[CTRL_COLTEST];
    end
  end

  // restart reads back as one for a single cycle only
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      restart <= 1'h0;
    else
      restart <= plain_wr && wr.data[CTRL_AN_RST] &&
                 !wr.data[CTRL_PDOWN];
  end

  //////////////////////////////////////////////////////////////////////////
  // core controls, all registered; power down silences the core
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      core_enable_o <= 1'h0;
      core_reset_o  <= 1'h1;
      loopback_o    <= 1'h0;
      isolate_o     <= 1'h0;
      col_test_o    <= 1'h0;
      an_enable_o   <= 1'h0;
      an_restart_o  <= 1'h0;
      speed_100_o   <= 1'h0;
      full_duplex_o <= 1'h0;
    end
    else
    begin
      core_enable_o <= !pd && !busy;
      core_reset_o  <= busy;
      loopback_o    <= loopback && !pd;
      isolate_o     <= iso;
      col_test_o    <= col && !pd;
      an_enable_o   <= an_en && !pd;
      an_restart_o  <= restart && an_en;
      speed_100_o   <= an_en ? an_speed_100_i : speed;
      full_duplex_o <= an_en ? an_full_duplex_i : duplex;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read side
  assign ctrl_word = {busy, loopback, speed, an_en, pd, iso, restart,
                      duplex, col, 7'h00};

  always_comb
  begin
    rd_data = 16'h0000;
    unique case (rd_addr)
      REG_CTRL:
        rd_data = ctrl_word;
      REG_STAT:
      begin
        rd_data = STAT_FIXED;
        rd_data[STAT_AN_DONE] = an_done_i;
        rd_data[STAT_LINK]    = link_up_i;
      end
      default:
        rd_data = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // core_reset_o trails busy by one flop, so it is checked a cycle later
  soft_rst_end_a: assert property (
    srst_start |-> ##SRST_CHK !busy ##1 !core_reset_o)
    else $error("soft reset did not end on time");

  soft_rst_flag_a: assert property (
    srst_start |=> ctrl_word[CTRL_RESET] ##1 core_reset_o)
    else $error("soft reset bit not showing");

  an_speed_a: assert property (
    an_en |=> speed_100_o == $past(an_speed_100_i))
    else $error("speed not taken from auto-negotiation");

  man_duplex_a: assert property (
    !an_en |=> full_duplex_o == $past(duplex))
    else $error("manual duplex not applied");

  pd_wake_a: assert property (
    wake_wr |=> (!pd && !busy))
    else $error("first reset write in power down misbehaved");

  isolate_pin_a: assert property (
    plain_wr |=> ##1 isolate_o == $past(wr.data[CTRL_ISOLATE], 2))
    else $error("isolate write not reflected");

  restart_pulse_a: assert property (
    restart |=> !restart)
    else $error("restart bit did not self-clear");

  strap_take_a: assert property (
    strap_load |=> (speed == $past(strap_s.speed_100) &&
                    an_en == $past(strap_s.autoneg_enable_strap) &&
                    iso == $past(strap_s.isolate) &&
                    !col && !loopback))
    else $error("strap values not loaded");

  duplex_inv_a: assert property (
    strap_load |=> duplex != $past(strap_s.duplex))
    else $error("duplex not inverse of strap");

  pd_core_off_a: assert property (
    pd |=> (!core_enable_o && !loopback_o && !an_restart_o))
    else $error("core active during power down");

  reserved_zero_a: assert property (
    (rd_addr == REG_STAT |-> !rd_data[15]) and
    (rd_addr == REG_CTRL |-> rd_data[6:0] == 7'h00))
    else $error("reserved bits not zero");

  speed_man_a: assert property (
    !an_en |=> speed_100_o == $past(speed))
    else $error("manual speed not applied");

  an_duplex_a: assert property (
    an_en |=> full_duplex_o == $past(an_full_duplex_i))
    else $error("duplex not taken from auto-negotiation");

  restart_out_a: assert property (
    (restart && an_en) |=> an_restart_o)
    else $error("restart pulse not passed on");

  wake_keep_a: assert property (
    wake_wr |=> ($stable(speed) && $stable(an_en) && $stable(loopback) &&
                 $stable(iso) && $stable(duplex)))
    else $error("wake write changed other fields");

  loop_pin_a: assert property (
    !pd |=> loopback_o == $past(loopback))
    else $error("loopback not reflected");

  col_pin_a: assert property (
    !pd |=> col_test_o == $past(col))
    else $error("collision test not reflected");

endmodule // pbc_phy_ctrl

// >>> verif/pbc_mdio_host.sv
// Purpose: station management controller model driving MDC/MDIO frames
// Assumes: MDC period of 16 reference clocks, MDIO pulled up when released
// Notes:   MDC rests low between frames; tasks are called from the bench
`timescale 1ns/10ps
module pbc_mdio_host (
  // reference clock
  input  wire logic ref_clk_i,
  // management pins
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  initial
  begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b1;
    mdio_oe_o = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // one bit: data changes while MDC is low, sampled just before the rise
  task automatic bit_cycle(input logic drv, input logic val,
                           output logic smp);
    @(negedge ref_clk_i);
    mdc_o     = 1'b0;
    mdio_oe_o = drv;
    mdio_o    = val;
    repeat (8) @(negedge ref_clk_i);
    smp   = mdio_i;
    mdc_o = 1'b1;
    repeat (7) @(negedge ref_clk_i);
  endtask

  // whole frame with preamble; read turnaround releases the line
  task automatic xfer(input logic rd, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, rd ? 2'b10 : 2'b01, pa, ra};
    for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    bit_cycle(!rd, 1'b1, s);
    bit_cycle(!rd, 1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      bit_cycle(!rd, wd[i], s);
      rdat[i] = s;
    end
    @(negedge ref_clk_i);
    mdc_o     = 1'b0;
    mdio_oe_o = 1'b0;
  endtask
endmodule // pbc_mdio_host

// >>> verif/tb_top.sv
// Purpose: self-checking bench of the basic control register block
// Assumes: one 100 MHz clock, straps held steady around each reset
// Notes:   integer model of the control word checked after every control-word read
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  import pbc_pkg::*;
  localparam logic [4:0] PA = 5'h03;
  logic          clk, rst_b, mdc, mdio_w, dut_mdio, dut_oe, host_mdio, host_oe;
  logic          an_done, an_spd, an_fdx, link_up;
  logic          core_en, core_rst, lpbk, iso, colt, an_en, an_rst, spd, fdx;
  pbc_strap_type strap;
  int            fails, check_count, restart_cnt, model, c0, rst_cyc;
  logic [31:0]   seed, tmp;
  logic [15:0]   d, w;

  // released line floats high through the pull-up
  assign mdio_w = dut_oe ? dut_mdio : (host_oe ? host_mdio : 1'b1);

  pbc_phy_ctrl #(.PHY_ADDR(PA)) pbc_phy_ctrl_i (
    .ref_clk_i(clk), .rst_b_i(rst_b), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(dut_mdio), .mdio_oe_o(dut_oe), .strap_i(strap),
    .an_done_i(an_done), .an_speed_100_i(an_spd),
    .an_full_duplex_i(an_fdx), .link_up_i(link_up),
    .core_enable_o(core_en), .core_reset_o(core_rst), .loopback_o(lpbk),
    .isolate_o(iso), .col_test_o(colt), .an_enable_o(an_en),
    .an_restart_o(an_rst), .speed_100_o(spd), .full_duplex_o(fdx));

  pbc_mdio_host pbc_mdio_host_i (
    .ref_clk_i(clk), .mdio_i(mdio_w), .mdc_o(mdc),
    .mdio_o(host_mdio), .mdio_oe_o(host_oe));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // counted on the falling edge, away from the launching rising edge, so no race with the design's flops
  always @(negedge clk)
  begin
    if (an_rst === 1'b1) restart_cnt++;
    if (core_rst === 1'b1) rst_cyc++;
  end

  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xrand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int dflt();
    return (int'(strap.speed_100) << 13) |
           (int'(strap.autoneg_enable_strap) << 12) |
           (int'(strap.isolate) << 10) | (int'(!strap.duplex) << 8);
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // model follows only writes that reach this device's control word
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
                    input logic [15:0] wv);
    logic [15:0] dummy;
    pbc_mdio_host_i.xfer(1'b0, pa, ra, wv, dummy);
    if (pa == PA && ra == REG_CTRL)
    begin
      if (wv[15] && model[11]) model[11] = 1'b0;
      else if (wv[15]) model = dflt();
      else model = int'(wv) & 32'h7D80;
    end
    repeat (30) @(negedge clk);
  endtask

  task automatic rd(input logic [4:0] ra, output logic [15:0] dv);
    pbc_mdio_host_i.xfer(1'b1, PA, ra, 16'h0000, dv);
  endtask

  task automatic chk_outs();
    logic a;
    a = model[12];
    `CHK("speed", a ? an_spd : model[13], spd)
    `CHK("duplex", a ? an_fdx : model[8], fdx)
    `CHK("an_enable", model[12] & !model[11], an_en)
    `CHK("isolate", model[10], iso)
    `CHK("loopback", model[14] & !model[11], lpbk)
    `CHK("col_test", model[7] & !model[11], colt)
    `CHK("core_enable", !model[11], core_en)
    `CHK("core_reset", 1'b0, core_rst)
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    complete_run();
  end

  initial
  begin
    seed        = 32'h3503A1BC;
    fails       = 0;
    check_count = 0;
    restart_cnt = 0;
    rst_cyc     = 0;
    rst_b       = 1'b0;
    tmp         = xrand();
    strap       = tmp[3:0];
    an_done     = tmp[4];
    link_up     = tmp[5];
    an_spd      = tmp[6];
    an_fdx      = tmp[7];
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    model = dflt();
    rd(REG_CTRL, d);
    `CHK("ctrl after reset", model[15:0], d)
    rd(REG_STAT, d);
    `CHK("status", STAT_FIXED | {an_done, 5'h00} | {link_up, 2'h0}, d)
    rd(5'h02, d);
    `CHK("unmapped read", 16'h0000, d)
    chk_outs();
    $display("test reset defaults done");
    for (int i = 0; i < 8; i++)
    begin
      tmp    = xrand();
      an_spd = tmp[20];
      an_fdx = tmp[21];
      w      = tmp[15:0] & 16'h77FF;
      w[12]  = i[0];
      w[9]   = i[1] | tmp[9];
      c0     = restart_cnt;
      wr(PA, REG_CTRL, w);
      `CHK("restart pulses", int'(w[9] & w[12]), restart_cnt - c0)
      wr(PA + 5'h01, REG_CTRL, ~w);
      wr(PA, REG_STAT, ~w);
      rd(REG_CTRL, d);
      `CHK("ctrl readback", model[15:0], d)
      chk_outs();
    end
    $display("test field writes done");
    tmp   = xrand();
    strap = tmp[3:0];
    rst_cyc = 0;
    wr(PA, REG_CTRL, 16'hC580);
    `CHK("soft reset cycles", SRST_CYCLES, rst_cyc)
    rd(REG_CTRL, d);
    `CHK("ctrl after soft reset", model[15:0], d)
    chk_outs();
    $display("test soft reset done");
    wr(PA, REG_CTRL, 16'h4880);
    chk_outs();
    rd(REG_CTRL, d);
    `CHK("ctrl in power down", model[15:0], d)
    strap = ~strap;
    rst_cyc = 0;
    wr(PA, REG_CTRL, 16'h8000);
    `CHK("wake reset cycles", 0, rst_cyc)
    rd(REG_CTRL, d);
    `CHK("ctrl after first reset", model[15:0], d)
    chk_outs();
    rst_cyc = 0;
    wr(PA, REG_CTRL, 16'h8000);
    `CHK("full reset cycles", SRST_CYCLES, rst_cyc)
    rd(REG_CTRL, d);
    `CHK("ctrl after second reset", model[15:0], d)
    chk_outs();
    $display("test power down exit done");
    complete_run();
  end
endmodule // tb_top
